// File: mss_stop_select.sv
/*
  mss_stop_select: stop method selection for a motor drive. decodes the two
  start inputs, decides between ramp-down and timed output shutoff, holds
  the stop method setting and guards restarts while coasting.
  assumes: all inputs synchronous to ref_clk; motor_stopped comes from the
  speed loop; the ramp generator obeys decel_stop_req and follow_speed_cmd.
*/
// What this block does
// - setting 0-100: two starts, coast after delay
// - setting 1000-1100: coast after setting minus 1000
// - setting 9999 or 8888: decelerate on start off
// - 8888 and 1000-1100: start plus direction inputs
// - running indicator drops when output shuts off
// - coast modes follow speed command until shutoff
// - pre-excitation input forces deceleration stop
// - override modes ignore the stop selection
// - no restart while coasting until motor stopped
// - setting writes only when display select zero
`timescale 1ns/1ps
module mss_stop_select #(
  parameter int unsigned CYC_PER_SEC = mss_pkg::SEC_CYCLES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic                       forward_start_input,
  input  wire logic                       reverse_or_direction_input,
  input  wire logic                       motor_stopped,
  input  wire logic                       pre_excitation_active,
  input  wire logic                       pre_excitation_input,
  input  wire logic                       position_ctrl_active,
  input  wire logic                       panel_unit_stop,
  input  wire logic                       comm_error_stop,
  input  wire logic                       jog_mode_active,
  input  wire logic                       setting_wr,
  input  wire logic [mss_pkg::SET_W-1:0]  setting_wdata,
  input  wire logic [mss_pkg::DISP_W-1:0] extended_display_select,
  output logic [mss_pkg::SET_W-1:0]       stop_method_setting,
  output logic                            setting_wr_rejected,
  output logic                            output_enable,
  output logic                            running_indicator,
  output logic                            follow_speed_cmd,
  output logic                            decel_stop_req,
  output logic                            coasting,
  output logic                            dir_reverse
);
  import mss_pkg::*;

  // all block state in one record; outputs are registered fields
  typedef struct packed {
    mss_state_t       state;    // operating state
    logic [SET_W-1:0] setting;  // stop method setting
    logic             rej;      // write refused, one-cycle pulse
    logic             out_en;   // output stage on
    logic             follow;   // ramp follows speed command
    logic             decel;    // ramp-down request
    logic             coast;    // output off, motor coasting
    logic             rev;      // reverse direction selected
  } mss_ctl_t;

  mss_ctl_t ctl;
  mss_ctl_t next_ctl;

  // decoded view of the setting and inputs
  logic             dir_mode;     // start plus direction interpretation
  logic             decel_sel;    // stop by ramp-down
  logic             start_now;    // a valid start is present
  logic             rev_now;      // requested direction is reverse
  logic             override;     // stop selection overruled
  logic [SEC_W-1:0] delay_secs;   // coast delay in seconds
  logic             wr_valid;     // written value is a legal setting
  logic             tmr_load;     // arm the coast delay
  logic             tmr_cancel;   // drop a pending delay
  logic             tmr_done;     // coast delay elapsed

  // setting decode
  always_comb begin
    dir_mode  = (ctl.setting == SET_DECEL_DIR) ||
                ((ctl.setting >= SET_DIR_MIN) && (ctl.setting <= SET_DIR_MAX));
    decel_sel = (ctl.setting == SET_DECEL) || (ctl.setting == SET_DECEL_DIR);
    // delay in seconds: offset range subtracts its base
    if (ctl.setting >= SET_DIR_MIN) begin
      delay_secs = SEC_W'(ctl.setting - SET_DIR_MIN);
    end else begin
      delay_secs = SEC_W'(ctl.setting);
    end
  end

  // start input interpretation
  always_comb begin
    if (dir_mode) begin
      // first input starts, second picks the direction
      start_now = forward_start_input;
      rev_now   = reverse_or_direction_input;
    end else begin
      // both inputs on at once cancel each other: no start
      start_now = forward_start_input ^ reverse_or_direction_input;
      rev_now   = reverse_or_direction_input & ~forward_start_input;
    end
  end

  // functions that overrule the selected stop method
  always_comb begin
    override = position_ctrl_active | panel_unit_stop |
               comm_error_stop | jog_mode_active;
    if (pre_excitation_active && pre_excitation_input) begin
      override = 1'b1;
    end
  end

  // only the documented setting values are stored
  always_comb begin
    wr_valid = (setting_wdata <= SET_COAST_MAX) ||
               ((setting_wdata >= SET_DIR_MIN) && (setting_wdata <= SET_DIR_MAX)) ||
               (setting_wdata == SET_DECEL) || (setting_wdata == SET_DECEL_DIR);
  end

  // next-state logic
  always_comb begin
    next_ctl   = ctl;
    next_ctl.rej = 1'b0;
    tmr_load   = 1'b0;
    tmr_cancel = 1'b0;

    // setting write; a refused write leaves the old value standing
    if (setting_wr) begin
      if ((extended_display_select == DISP_OPEN) && wr_valid) begin
        next_ctl.setting = setting_wdata;
      end else begin
        next_ctl.rej = 1'b1;
      end
    end

    case (ctl.state)
      ST_IDLE: begin
        // a start from standstill begins running
        if (start_now) begin
          next_ctl.state = ST_RUN;
          next_ctl.rev   = rev_now;
        end
      end
      ST_RUN: begin
        if (start_now) begin
          // direction tracks the inputs while running
          next_ctl.rev = rev_now;
        end else if (decel_sel || override) begin
          next_ctl.state = ST_DECEL;
        end else begin
          next_ctl.state = ST_DELAY;
          tmr_load       = 1'b1;
        end
      end
      ST_DELAY: begin
        // still following speed command while waiting
        if (start_now) begin
          next_ctl.state = ST_RUN;
          next_ctl.rev   = rev_now;
          tmr_cancel     = 1'b1;
        end else if (override) begin
          // late override still turns the stop into a ramp-down
          next_ctl.state = ST_DECEL;
          tmr_cancel     = 1'b1;
        end else if (tmr_done) begin
          next_ctl.state = ST_COAST;
          tmr_cancel     = 1'b1;
        end
      end
      ST_DECEL: begin
        // a new start during ramp-down resumes running
        if (start_now) begin
          next_ctl.state = ST_RUN;
          next_ctl.rev   = rev_now;
        end else if (motor_stopped) begin
          next_ctl.state = ST_IDLE;
        end
      end
      ST_COAST: begin
        // start is ignored here; only standstill ends the coast
        if (motor_stopped) begin
          next_ctl.state = ST_IDLE;
        end
      end
      default: begin
        next_ctl.state = ST_IDLE;
      end
    endcase

    // registered outputs follow the next state
    next_ctl.out_en = (next_ctl.state == ST_RUN) ||
                      (next_ctl.state == ST_DELAY) ||
                      (next_ctl.state == ST_DECEL);
    next_ctl.follow = (next_ctl.state == ST_RUN) ||
                      (next_ctl.state == ST_DELAY);
    next_ctl.decel  = (next_ctl.state == ST_DECEL);
    next_ctl.coast  = (next_ctl.state == ST_COAST);
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl         <= '0;
      ctl.state   <= ST_IDLE;
      ctl.setting <= SET_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  // coast delay counter
  mss_sec_timer #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (tmr_load),
    .cancel  (tmr_cancel),
    .seconds (delay_secs),
    .done    (tmr_done)
  );

  // outputs; indicator shares the output stage flop so they fall together
  assign stop_method_setting = ctl.setting;
  assign setting_wr_rejected = ctl.rej;
  assign output_enable       = ctl.out_en;
  assign running_indicator   = ctl.out_en;
  assign follow_speed_cmd    = ctl.follow;
  assign decel_stop_req      = ctl.decel;
  assign coasting            = ctl.coast;
  assign dir_reverse         = ctl.rev;

  // checks
  a_decel_on_off: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_RUN) && !start_now && decel_sel |=> decel_stop_req && output_enable)
    else $error("decel mode did not ramp down");

  a_coast_delay_entry: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_RUN) && !start_now && !decel_sel && !override
    |=> (ctl.state == ST_DELAY) && follow_speed_cmd)
    else $error("coast mode did not start delay");

  a_delay_expiry: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_DELAY) && tmr_done && !start_now && !override
    |=> coasting && !output_enable)
    else $error("output not shut off after delay");

  a_indicator_off: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(coasting) |-> !running_indicator && $past(running_indicator))
    else $error("indicator outlived output stage");

  a_delay_follows: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_DELAY) |-> follow_speed_cmd && !decel_stop_req)
    else $error("speed command not followed in delay");

  a_preexc_decel: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_RUN) && !start_now && pre_excitation_active && pre_excitation_input
    |=> decel_stop_req)
    else $error("pre-excitation stop did not ramp");

  a_override_decel: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_RUN) && !start_now && jog_mode_active |=> decel_stop_req)
    else $error("override did not force ramp-down");

  a_coast_hold: assert property (@(posedge ref_clk) disable iff (reset)
    coasting && !motor_stopped |=> !output_enable ##1 !follow_speed_cmd)
    else $error("restart while coasting");

  a_write_lock: assert property (@(posedge ref_clk) disable iff (reset)
    setting_wr && (extended_display_select != DISP_OPEN)
    |=> $stable(stop_method_setting) && setting_wr_rejected)
    else $error("locked setting was written");

  a_delay_cancel: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_DELAY) && start_now |=> (ctl.state == ST_RUN) && !tmr_done)
    else $error("restart did not cancel delay");

  a_dir_latch: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_IDLE) && dir_mode && forward_start_input
    |=> dir_reverse == $past(reverse_or_direction_input))
    else $error("direction input not taken");

  // no disable here: this one looks at what reset itself leaves behind
  a_reset_defaults: assert property (@(posedge ref_clk)
    reset |=> (stop_method_setting == SET_RESET) && !output_enable && !coasting)
    else $error("reset left the block active");

  a_write_accept: assert property (@(posedge ref_clk) disable iff (reset)
    setting_wr && (extended_display_select == DISP_OPEN) && wr_valid
    |=> (stop_method_setting == $past(setting_wdata)) && !setting_wr_rejected)
    else $error("open write was not stored");

  // direction may change while running; the flop must follow it
  a_dir_tracks: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_RUN) && start_now |=> dir_reverse == $past(rev_now))
    else $error("direction did not track inputs");

  a_coast_no_restart: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_COAST) && start_now && !motor_stopped |=> coasting && !output_enable)
    else $error("start accepted while coasting");

  a_decel_to_idle: assert property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_DECEL) && !start_now && motor_stopped |=> !output_enable && !decel_stop_req)
    else $error("ramp-down did not end at standstill");

  // scenario covers: each should be reached by the bench
  c_coast_done: cover property (@(posedge ref_clk) disable iff (reset)
    coasting ##1 !coasting && !output_enable);
  c_decel_done: cover property (@(posedge ref_clk) disable iff (reset)
    decel_stop_req ##1 !decel_stop_req && !output_enable);
  c_cancel: cover property (@(posedge ref_clk) disable iff (reset)
    (ctl.state == ST_DELAY) && start_now);
  c_rejected: cover property (@(posedge ref_clk) disable iff (reset)
    setting_wr_rejected);
  c_dir_run: cover property (@(posedge ref_clk) disable iff (reset)
    dir_mode && output_enable && dir_reverse);

endmodule : mss_stop_select

// File: mss_pkg.sv
/*
  mss_pkg: constants, state encoding and timing counts for the motor
  stop method selection block.
  assumes: the user supplies a 200 MHz clock; settings are plain binary.
*/
package mss_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ        = 200_000_000; // ref_clk rate
  localparam int unsigned DELAY_UNIT_S  = 1;           // coast delay unit, seconds
  localparam int unsigned SEC_CYCLES    = DELAY_UNIT_S * CLK_HZ; // cycles per unit

  // stop method setting layout
  localparam int          SET_W         = 14;          // holds 0 .. 9999
  localparam int          SEC_W         = 7;           // holds 0 .. 100 seconds
  localparam logic [13:0] SET_RESET     = 14'h270f;    // 9999, decelerate
  localparam logic [13:0] SET_DECEL     = 14'h270f;    // 9999, two-start decel
  localparam logic [13:0] SET_DECEL_DIR = 14'h22b8;    // 8888, start/dir decel
  localparam logic [13:0] SET_COAST_MAX = 14'h0064;    // 100, top of plain range
  localparam logic [13:0] SET_DIR_MIN   = 14'h03e8;    // 1000, start/dir range
  localparam logic [13:0] SET_DIR_MAX   = 14'h044c;    // 1100, start/dir range

  // extended display select value that opens the setting for writes
  localparam int          DISP_W        = 14;
  localparam logic [13:0] DISP_OPEN     = 14'h0000;

  // operating states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,  // stopped, output off
    ST_RUN   = 3'h1,  // start active, following speed command
    ST_DELAY = 3'h2,  // start off, coast delay running
    ST_DECEL = 3'h3,  // ramping down to a stop
    ST_COAST = 3'h4   // output shut off, motor coasting
  } mss_state_t;

endpackage : mss_pkg

// File: mss_sec_timer.sv
/*
  mss_sec_timer: whole-second delay counter for the coast delay.
  assumes: load and cancel are single-cycle strobes from the owner;
  cyc_per_sec is at least 2.
*/
`timescale 1ns/1ps
module mss_sec_timer #(
  parameter int unsigned CYC_PER_SEC = mss_pkg::SEC_CYCLES
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  input  wire logic                     load,
  input  wire logic                     cancel,
  input  wire logic [mss_pkg::SEC_W-1:0] seconds,
  output logic                          done
);
  import mss_pkg::*;

  // whole timer state in one record
  typedef struct packed {
    logic             busy;     // counting
    logic             done;     // delay elapsed, held until reload/cancel
    logic [SEC_W-1:0] sec_left; // whole seconds still to go
    logic [31:0]      tick;     // cycles within the current second
  } mss_tmr_t;

  mss_tmr_t tmr;
  mss_tmr_t next_tmr;

  localparam logic [31:0] TICK_LAST = 32'(CYC_PER_SEC - 1);

  // next-state: load wins over cancel so a fresh delay is never dropped
  always_comb begin
    next_tmr = tmr;
    if (load) begin
      next_tmr.busy     = (seconds != '0);
      next_tmr.done     = (seconds == '0);
      next_tmr.sec_left = seconds;
      next_tmr.tick     = 32'h0;
    end else if (cancel) begin
      next_tmr = '0;
    end else if (tmr.busy) begin
      if (tmr.tick == TICK_LAST) begin
        next_tmr.tick     = 32'h0;
        next_tmr.sec_left = tmr.sec_left - 7'h01;
        if (tmr.sec_left == 7'h01) begin
          next_tmr.busy = 1'b0;
          next_tmr.done = 1'b1;
        end
      end else begin
        next_tmr.tick = tmr.tick + 32'h1;
      end
    end
  end

  // register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tmr <= '0;
    end else begin
      tmr <= next_tmr;
    end
  end

  assign done = tmr.done;

endmodule : mss_sec_timer

// File: mss_motor_model.sv
/*
  mss_motor_model: behavioural stand-in for the driven motor on the far
  side of the stop selection block; reports standstill after a spin-down.
  assumes: one clock shared with the block, synchronous active-high reset.
*/
`timescale 1ns/1ps
module mss_motor_model #(
  parameter int unsigned STOP_CYC = 6  // cycles to spin down once no longer driven along the speed command
) (
  input  wire logic ref_clk,           // shared clock
  input  wire logic reset,             // sync reset, motor at rest after it
  input  wire logic output_enable,     // output stage on
  input  wire logic follow_speed_cmd,  // speed command being followed
  output logic      motor_stopped      // high at standstill
);
  int unsigned spin_down;  // cycles since drive stopped pushing the motor

  // the motor only spins while driven along the speed command; ramp-down
  // and coasting both bring it to rest after the same span, which keeps
  // the bench timing simple but does not model a real inertia ratio
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spin_down <= STOP_CYC;  // starts at rest
    end else if (output_enable && follow_speed_cmd) begin
      spin_down <= 0;  // being driven, still turning
    end else if (spin_down < STOP_CYC) begin
      spin_down <= spin_down + 1;
    end
  end

  // standstill seen only after the full spin-down, so a coasting motor
  // cannot be reported stopped early
  assign motor_stopped = (spin_down >= STOP_CYC);
endmodule : mss_motor_model

// File: mss_stop_select_tb.sv
/*
  mss_stop_select_tb: self-checking bench for the stop method selection.
  assumes: mss_pkg and the design files are compiled first; the motor
  model answers standstill a fixed span after the drive lets go.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module mss_stop_select_tb;
  import mss_pkg::*;
  localparam int unsigned CYC  = 4;  // shortened second for simulation
  localparam int unsigned STOP = 6;  // motor spin-down span
  logic              ref_clk, reset, fwd, sec, motor_stopped, pre_act, pre_in, wr;
  logic [3:0]        ovr;            // position, panel, comm error, jog
  logic [SET_W-1:0]  wdata, setting;
  logic [DISP_W-1:0] disp;
  logic              rej, out_en, run_ind, follow, decel, coasting, dir_rev;
  int                err_count, samples_checked;

  mss_stop_select #(.CYC_PER_SEC(CYC)) dut (
    .ref_clk(ref_clk), .reset(reset), .forward_start_input(fwd),
    .reverse_or_direction_input(sec), .motor_stopped(motor_stopped),
    .pre_excitation_active(pre_act), .pre_excitation_input(pre_in),
    .position_ctrl_active(ovr[0]), .panel_unit_stop(ovr[1]),
    .comm_error_stop(ovr[2]), .jog_mode_active(ovr[3]), .setting_wr(wr),
    .setting_wdata(wdata), .extended_display_select(disp),
    .stop_method_setting(setting), .setting_wr_rejected(rej),
    .output_enable(out_en), .running_indicator(run_ind),
    .follow_speed_cmd(follow), .decel_stop_req(decel), .coasting(coasting),
    .dir_reverse(dir_rev));

  mss_motor_model #(.STOP_CYC(STOP)) motor (
    .ref_clk(ref_clk), .reset(reset), .output_enable(out_en),
    .follow_speed_cmd(follow), .motor_stopped(motor_stopped));

  // free-running 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // land just past an edge so registered outputs have settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  // drive both start inputs at an edge
  task automatic starts(input logic f, input logic s);
    @(posedge ref_clk);
    fwd <= f;
    sec <= s;
  endtask : starts

  // one write strobe; returns just after the sampling edge
  task automatic set_mode(input logic [SET_W-1:0] v, input logic [DISP_W-1:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    wdata <= v;
    disp  <= d;
    @(posedge ref_clk);
    wr    <= 1'b0;
    disp  <= 14'h0000;
    #1;
  endtask : set_mode

  // bounded wait for stop, then let the motor settle before a restart
  task automatic wait_idle;
    for (int i = 0; i < 300 && (out_en !== 1'b0 || coasting !== 1'b0); i++) wait_cyc(1);
    wait_cyc(STOP + 2);
    `CHK("out_en idle", 1'b0, out_en)
  endtask : wait_idle

  // ramp-down modes: run, drop start, expect deceleration request
  task automatic decel_run(input logic [SET_W-1:0] v, input logic f, input logic s);
    set_mode(v, 14'h0000);
    starts(f, s);
    wait_cyc(2);
    `CHK("out_en run", 1'b1, out_en)
    `CHK("dir_rev", 1'b1, dir_rev)
    starts(1'b0, 1'b0);
    wait_cyc(1);
    `CHK("decel", 1'b1, decel)
    `CHK("follow decel", 1'b0, follow)
    wait_idle();
  endtask : decel_run

  // coast modes: delay of d seconds, then output off, no restart meanwhile
  task automatic coast_run(input logic [SET_W-1:0] v, input int d, input logic f,
                           input logic s, input logic exp_dir);
    int off_after;
    off_after = d * CYC + 1;  // a zero delay shuts off at the edge after entry
    set_mode(v, 14'h0000);
    starts(f, s);
    wait_cyc(2);
    `CHK("dir_rev", exp_dir, dir_rev)
    starts(1'b0, 1'b0);
    wait_cyc(1);
    `CHK("follow delay", 1'b1, follow)
    `CHK("decel delay", 1'b0, decel)
    wait_cyc(off_after - 1);
    `CHK("out_en delay", 1'b1, out_en)
    wait_cyc(1);
    `CHK("out_en coast", 1'b0, out_en)
    `CHK("run_ind coast", 1'b0, run_ind)
    `CHK("coasting", 1'b1, coasting)
    starts(1'b1, 1'b0);
    wait_cyc(2);
    `CHK("no restart", 1'b0, out_en)
    wait_cyc(STOP + 3);
    `CHK("restart", 1'b1, out_en)
    starts(1'b0, 1'b0);
    wait_idle();
  endtask : coast_run

  // start back during the delay cancels the pending shutoff
  task automatic cancel_run;
    set_mode(14'h0003, 14'h0000);
    starts(1'b1, 1'b0);
    wait_cyc(2);
    starts(1'b0, 1'b0);
    wait_cyc(3);
    starts(1'b1, 1'b0);
    wait_cyc(3 * CYC + 4);
    `CHK("cancel on", 1'b1, out_en)
    `CHK("cancel coast", 1'b0, coasting)
    starts(1'b0, 1'b0);
    wait_idle();
  endtask : cancel_run

  // coast mode overridden: pre-excitation (idx 4) or one of four overrides
  task automatic override_run(input int idx);
    set_mode(14'h0002, 14'h0000);
    starts(1'b1, 1'b0);
    wait_cyc(2);
    @(posedge ref_clk);
    fwd <= 1'b0;
    if (idx == 4) begin
      pre_act <= 1'b1;
      pre_in  <= 1'b1;
    end else begin
      ovr[idx] <= 1'b1;
    end
    wait_cyc(1);
    `CHK("decel override", 1'b1, decel)
    `CHK("out_en override", 1'b1, out_en)
    @(posedge ref_clk);
    ovr     <= 4'h0;
    pre_act <= 1'b0;
    pre_in  <= 1'b0;
    wait_idle();
  endtask : override_run

  // verdict in one place
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // cut a hang short well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("unexpected watchdog expected 0 seen 1");
    close_out();
  end

  // main sequence
  initial begin
    err_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    {fwd, sec, pre_act, pre_in, wr} = 5'h00;
    ovr   = 4'h0;
    wdata = 14'h0000;
    disp  = 14'h0000;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    wait_cyc(1);
    `CHK("setting reset", SET_RESET, setting)
    `CHK("out_en reset", 1'b0, out_en)
    set_mode(SET_DECEL_DIR, 14'h0000);
    `CHK("write open", SET_DECEL_DIR, setting)
    set_mode(14'h0005, 14'h0001);
    `CHK("write closed", SET_DECEL_DIR, setting)
    `CHK("rejected", 1'b1, rej)
    set_mode(14'h0fff, 14'h0000);
    `CHK("write invalid", SET_DECEL_DIR, setting)
    `CHK("rejected invalid", 1'b1, rej)
    decel_run(SET_DECEL, 1'b0, 1'b1);
    decel_run(SET_DECEL_DIR, 1'b1, 1'b1);
    coast_run(14'h0000, 0, 1'b0, 1'b1, 1'b1);
    coast_run(14'h0002, 2, 1'b1, 1'b0, 1'b0);
    coast_run(14'h03ea, 2, 1'b1, 1'b1, 1'b1);
    cancel_run();
    for (int i = 0; i < 5; i++) override_run(i);
    close_out();
  end
endmodule : mss_stop_select_tb
